// ---- verilog/ref_input_config.sv ----
// Register bank for the reference input path and loop front-end dividers.
// Assumes one 40 MHz clock, a synchronous active-high reset and a plain register port.
//
// Operation
// - Bypass bit skips the glitch-free reference mux
// - Keep bit clear: secondary buffer off after switchback
// - Keep bit set: secondary buffer stays on
// - Bit 1 selects secondary buffer gain, resets high
// - Bit 0 selects primary buffer gain, resets high
// - Reference divider code n divides by n+1
// - Feedback divider code n divides by n+1
// - Automatic selection prefers the primary input
`timescale 1ns/1ps
`default_nettype none

module ref_input_config (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register port.
  input wire logic [clkcfg_pkg::ADDR_W-1:0] addr,
  input wire logic [clkcfg_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [clkcfg_pkg::DATA_W-1:0] rd_data,
  // Reference status inputs.
  input wire logic ref_select_pin,
  input wire logic primary_ok,
  input wire logic secondary_ok,
  // Pulse streams to be divided.
  input wire logic ref_edge,
  input wire logic feedback_edge,
  // Configuration outputs.
  output clkcfg_pkg::input_ctl_s input_ctl,
  output logic [clkcfg_pkg::REF_DIV_W-1:0] reference_divide_code,
  output logic [clkcfg_pkg::FB_DIV_W-1:0] feedback_divide_code,
  // Reference path state.
  output logic use_secondary,
  output logic secondary_buffer_on,
  // Divided pulses.
  output logic ref_div_tick,
  output logic feedback_div_tick
);

  logic [clkcfg_pkg::SEL_W-1:0] loop_reference_select;
  logic wr_ctl;
  logic wr_rdiv;
  logic wr_mdiv;
  logic wr_sel;

  // ==========================================================================
  // Address decode.
  assign wr_ctl = wr_en && addr == clkcfg_pkg::OFF_INPUT_CTL;
  assign wr_rdiv = wr_en && addr == clkcfg_pkg::OFF_REF_DIV;
  assign wr_mdiv = wr_en && addr == clkcfg_pkg::OFF_FB_DIV;
  assign wr_sel = wr_en && addr == clkcfg_pkg::OFF_REF_SELECT;

  // ==========================================================================
  // Input clock control: all eight bits are writable and stored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      input_ctl <= clkcfg_pkg::input_ctl_s'(clkcfg_pkg::CTL_RESET);
    end else if (wr_ctl) begin
      input_ctl <= clkcfg_pkg::input_ctl_s'(wr_data);
    end
  end

  // Reference divider code; bits above the field are dropped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reference_divide_code <= clkcfg_pkg::REF_DIV_RESET;
    end else if (wr_rdiv) begin
      reference_divide_code <= wr_data[clkcfg_pkg::REF_DIV_W-1:0];
    end
  end

  // Feedback divider code; bits above the field are dropped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      feedback_divide_code <= clkcfg_pkg::FB_DIV_RESET;
    end else if (wr_mdiv) begin
      feedback_divide_code <= wr_data[clkcfg_pkg::FB_DIV_W-1:0];
    end
  end

  // Loop reference selection code.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      loop_reference_select <= clkcfg_pkg::SEL_RESET;
    end else if (wr_sel) begin
      loop_reference_select <= wr_data[clkcfg_pkg::SEL_W-1:0];
    end
  end

  // ==========================================================================
  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge core_clk) begin
    if (rst || !rd_en) begin
      rd_data <= '0;
    end else begin
      unique case (addr)
        clkcfg_pkg::OFF_INPUT_CTL: rd_data <= input_ctl;
        clkcfg_pkg::OFF_REF_DIV: rd_data <= {5'h00, reference_divide_code};
        clkcfg_pkg::OFF_FB_DIV: rd_data <= {3'h0, feedback_divide_code};
        clkcfg_pkg::OFF_REF_SELECT: rd_data <= {6'h00, loop_reference_select};
        clkcfg_pkg::OFF_REF_STATUS: rd_data <= {6'h00, secondary_buffer_on, use_secondary};
        default: rd_data <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Reference selection and secondary buffer power.
  ref_input_selector #(
    .HOLD_CYCLES(clkcfg_pkg::HANDOVER_CYCLES)
  ) u_selector (
    .clk(core_clk),
    .rst(rst),
    .mode(loop_reference_select),
    .mux_skip(input_ctl.ref_switch_mux_skip),
    .keep_sec(input_ctl.keep_secondary_xtal_on),
    .select_pin(ref_select_pin),
    .pri_ok(primary_ok),
    .sec_ok(secondary_ok),
    .use_sec(use_secondary),
    .sec_buf_on(secondary_buffer_on)
  );

  // ==========================================================================
  // Reference divider.
  ratio_divider #(
    .CODE_W(clkcfg_pkg::REF_DIV_W)
  ) u_ref_div (
    .clk(core_clk),
    .rst(rst),
    .code(reference_divide_code),
    .in_pulse(ref_edge),
    .out_pulse(ref_div_tick)
  );

  // Feedback divider.
  ratio_divider #(
    .CODE_W(clkcfg_pkg::FB_DIV_W)
  ) u_fb_div (
    .clk(core_clk),
    .rst(rst),
    .code(feedback_divide_code),
    .in_pulse(feedback_edge),
    .out_pulse(feedback_div_tick)
  );

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // With the mux skipped, a forced secondary is taken on the next edge.
  property p_skip_immediate;
    input_ctl.ref_switch_mux_skip && loop_reference_select == clkcfg_pkg::SEL_SECONDARY |=> use_secondary;
  endproperty
  a_skip_immediate: assert property (p_skip_immediate) else $error("bypassed switch not immediate");

  // Through the mux, four steady cycles of wanting secondary complete the switch.
  property p_mux_handover;
    (!input_ctl.ref_switch_mux_skip && loop_reference_select == clkcfg_pkg::SEL_SECONDARY)[*4]
      |=> use_secondary;
  endproperty
  a_mux_handover: assert property (p_mux_handover) else $error("mux handover too slow");

  // Switching back with keep clear powers the secondary buffer down.
  property p_sec_off;
    $fell(use_secondary) && !$past(input_ctl.keep_secondary_xtal_on) |-> !secondary_buffer_on;
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("secondary buffer left on");

  // Switching back with keep set leaves the secondary buffer on.
  property p_sec_keep;
    $fell(use_secondary) && $past(input_ctl.keep_secondary_xtal_on) |-> secondary_buffer_on;
  endproperty
  a_sec_keep: assert property (p_sec_keep) else $error("secondary buffer dropped");

  // Secondary gain follows bit 1 of a control write.
  property p_sec_gain;
    wr_ctl |=> input_ctl.secondary_buffer_gain == $past(wr_data[clkcfg_pkg::CTL_SEC_GAIN_BIT]);
  endproperty
  a_sec_gain: assert property (p_sec_gain) else $error("secondary gain not stored");

  // Primary gain follows bit 0 of a control write.
  property p_pri_gain;
    wr_ctl |=> input_ctl.primary_buffer_gain == $past(wr_data[clkcfg_pkg::CTL_PRI_GAIN_BIT]);
  endproperty
  a_pri_gain: assert property (p_pri_gain) else $error("primary gain not stored");

  // A nonzero reference code never yields two ticks in a row.
  property p_rdiv_gap;
    ref_div_tick && reference_divide_code != '0 |=> !ref_div_tick;
  endproperty
  a_rdiv_gap: assert property (p_rdiv_gap) else $error("reference divider ticked twice");

  // A zero feedback code passes each pulse on the next edge.
  property p_mdiv_bypass;
    feedback_divide_code == '0 && feedback_edge |=> feedback_div_tick;
  endproperty
  a_mdiv_bypass: assert property (p_mdiv_bypass) else $error("feedback bypass lost a pulse");

  // Automatic mode with a good primary and no mux delay selects primary.
  property p_auto_primary;
    loop_reference_select == clkcfg_pkg::SEL_AUTO && primary_ok && input_ctl.ref_switch_mux_skip
      |=> !use_secondary;
  endproperty
  a_auto_primary: assert property (p_auto_primary) else $error("auto mode left primary");

  // Divider bits 7:5, reserved in both registers, read as zero.
  property p_rsvd_zero;
    rd_en && (addr == clkcfg_pkg::OFF_REF_DIV || addr == clkcfg_pkg::OFF_FB_DIV)
      |=> rd_data[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

  // A control read returns the stored control byte in the next cycle.
  property p_ctl_read;
    rd_en && addr == clkcfg_pkg::OFF_INPUT_CTL |=> rd_data == $past(input_ctl);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");

  // A reference divider write keeps only the low field bits.
  property p_rdiv_store;
    wr_rdiv |=> reference_divide_code == $past(wr_data[clkcfg_pkg::REF_DIV_W-1:0]);
  endproperty
  a_rdiv_store: assert property (p_rdiv_store) else $error("reference code not stored");

  // A feedback divider write keeps only the low field bits.
  property p_mdiv_store;
    wr_mdiv |=> feedback_divide_code == $past(wr_data[clkcfg_pkg::FB_DIV_W-1:0]);
  endproperty
  a_mdiv_store: assert property (p_mdiv_store) else $error("feedback code not stored");

  // A zero reference code passes each pulse on the next edge.
  property p_rdiv_bypass;
    reference_divide_code == '0 && ref_edge |=> ref_div_tick;
  endproperty
  a_rdiv_bypass: assert property (p_rdiv_bypass) else $error("reference bypass lost a pulse");

  // A nonzero feedback code never yields two ticks in a row.
  property p_mdiv_gap;
    feedback_div_tick && feedback_divide_code != '0 |=> !feedback_div_tick;
  endproperty
  a_mdiv_gap: assert property (p_mdiv_gap) else $error("feedback divider ticked twice");

  // The secondary buffer is powered whenever the secondary is taken.
  property p_sec_on_switch;
    $rose(use_secondary) |-> secondary_buffer_on;
  endproperty
  a_sec_on_switch: assert property (p_sec_on_switch) else $error("secondary taken unpowered");

  // Automatic mode falls back to a good secondary when primary fails.
  property p_auto_fallback;
    loop_reference_select == clkcfg_pkg::SEL_AUTO && !primary_ok && secondary_ok
      && input_ctl.ref_switch_mux_skip |=> use_secondary;
  endproperty
  a_auto_fallback: assert property (p_auto_fallback) else $error("auto mode kept failed primary");

  // With the mux skipped, a forced primary is taken on the next edge.
  property p_force_primary;
    loop_reference_select == clkcfg_pkg::SEL_PRIMARY && input_ctl.ref_switch_mux_skip |=> !use_secondary;
  endproperty
  a_force_primary: assert property (p_force_primary) else $error("forced primary not taken");

  // A selection write stores the low two bits.
  property p_sel_store;
    wr_sel |=> loop_reference_select == $past(wr_data[clkcfg_pkg::SEL_W-1:0]);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("selection code not stored");

  // A status read reports buffer power and the selected input.
  property p_status_read;
    rd_en && addr == clkcfg_pkg::OFF_REF_STATUS
      |=> rd_data == {6'h00, $past(secondary_buffer_on), $past(use_secondary)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  // Main scenarios.
  property p_cov_switchback;
    $fell(use_secondary);
  endproperty
  c_cov_switchback: cover property (p_cov_switchback);

  property p_cov_divide;
    reference_divide_code == 3'h7 && ref_div_tick;
  endproperty
  c_cov_divide: cover property (p_cov_divide);

  property p_cov_fb_divide;
    feedback_divide_code == 5'h1F && feedback_div_tick;
  endproperty
  c_cov_fb_divide: cover property (p_cov_fb_divide);

  property p_cov_handover;
    !input_ctl.ref_switch_mux_skip && $rose(use_secondary);
  endproperty
  c_cov_handover: cover property (p_cov_handover);

endmodule : ref_input_config

`default_nettype wire

// ---- verilog/clkcfg_pkg.sv ----
// Constants and types shared by the reference input and divider configuration bank.
// Assumes a single 40 MHz core clock and an 8-bit register port.
`default_nettype none

package clkcfg_pkg;

  // ==========================================================================
  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] OFF_INPUT_CTL = 8'h33;
  localparam logic [7:0] OFF_REF_DIV = 8'h34;
  localparam logic [7:0] OFF_FB_DIV = 8'h35;
  localparam logic [7:0] OFF_REF_SELECT = 8'h3E;
  localparam logic [7:0] OFF_REF_STATUS = 8'h3F;

  // ==========================================================================
  // Field positions and widths.
  localparam int CTL_SKIP_BIT = 7;
  localparam int CTL_KEEP_BIT = 2;
  localparam int CTL_SEC_GAIN_BIT = 1;
  localparam int CTL_PRI_GAIN_BIT = 0;
  localparam int REF_DIV_W = 3;
  localparam int FB_DIV_W = 5;
  localparam int SEL_W = 2;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CTL_RESET = 8'h03;
  localparam logic [REF_DIV_W-1:0] REF_DIV_RESET = 3'h0;
  localparam logic [FB_DIV_W-1:0] FB_DIV_RESET = 5'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h1;

  // ==========================================================================
  // Loop reference selection codes.
  localparam logic [SEL_W-1:0] SEL_AUTO = 2'h0;
  localparam logic [SEL_W-1:0] SEL_PIN = 2'h1;
  localparam logic [SEL_W-1:0] SEL_PRIMARY = 2'h2;
  localparam logic [SEL_W-1:0] SEL_SECONDARY = 2'h3;

  // ==========================================================================
  // Glitch-free handover time through the reference mux.
  localparam int CLK_PERIOD_NS = 25;
  localparam int HANDOVER_NS = 100;
  localparam int HANDOVER_CYCLES = (HANDOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Input clock control layout, bit 7 down to bit 0.
  typedef struct packed {
    logic ref_switch_mux_skip;
    logic [3:0] spare;
    logic keep_secondary_xtal_on;
    logic secondary_buffer_gain;
    logic primary_buffer_gain;
  } input_ctl_s;

endpackage : clkcfg_pkg

`default_nettype wire

// ---- verilog/ratio_divider.sv ----
// Programmable divider that thins a stream of input pulses.
// Assumes input pulses are one cycle wide and synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module ratio_divider #(
  parameter int CODE_W = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Ratio code and pulse stream.
  input wire logic [CODE_W-1:0] code,
  input wire logic in_pulse,
  output logic out_pulse
);

  logic [CODE_W-1:0] count_reg;

  // ==========================================================================
  // Code zero passes every pulse; code n passes one pulse in n+1.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      out_pulse <= 1'b0;
    end else begin
      out_pulse <= 1'b0;
      if (in_pulse) begin
        if (code == '0) begin
          count_reg <= '0;
          out_pulse <= 1'b1;
        end else if (count_reg >= code) begin
          count_reg <= '0;
          out_pulse <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule : ratio_divider

`default_nettype wire

// ---- verilog/ref_input_selector.sv ----
// Chooses the loop reference between primary and secondary inputs.
// Assumes input health flags and the select pin are synchronous levels.
`timescale 1ns/1ps
`default_nettype none

module ref_input_selector #(
  parameter int HOLD_CYCLES = clkcfg_pkg::HANDOVER_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Configuration.
  input wire logic [clkcfg_pkg::SEL_W-1:0] mode,
  input wire logic mux_skip,
  input wire logic keep_sec,
  // Reference status.
  input wire logic select_pin,
  input wire logic pri_ok,
  input wire logic sec_ok,
  // Results.
  output logic use_sec,
  output logic sec_buf_on
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic want_sec;
  logic switch_now;
  logic [CW-1:0] settle_reg;

  // Automatic choice: primary whenever it is good, else a good secondary.
  function automatic logic auto_pick(input logic p_ok, input logic s_ok, input logic cur);
    if (p_ok) return 1'b0;
    else if (s_ok) return 1'b1;
    else return cur;
  endfunction : auto_pick

  // ==========================================================================
  // Wanted input from the selection code.
  always_comb begin
    want_sec = use_sec;
    unique case (mode)
      clkcfg_pkg::SEL_AUTO: want_sec = auto_pick(pri_ok, sec_ok, use_sec);
      clkcfg_pkg::SEL_PIN: want_sec = select_pin ? auto_pick(pri_ok, sec_ok, use_sec) : 1'b0;
      clkcfg_pkg::SEL_PRIMARY: want_sec = 1'b0;
      clkcfg_pkg::SEL_SECONDARY: want_sec = 1'b1;
    endcase
  end

  // The glitch-free mux needs a settle period; bypass switches at once.
  assign switch_now = (want_sec != use_sec) && (mux_skip || settle_reg == CW'(HOLD_CYCLES - 1));

  // Settle counter runs while a change is pending.
  always_ff @(posedge clk) begin
    if (rst || want_sec == use_sec || switch_now) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  // Selected input.
  always_ff @(posedge clk) begin
    if (rst) begin
      use_sec <= 1'b0;
    end else if (switch_now) begin
      use_sec <= want_sec;
    end
  end

  // Secondary buffer power follows the switch back to primary.
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_buf_on <= 1'b1;
    end else if (switch_now) begin
      sec_buf_on <= want_sec | keep_sec;
    end
  end

endmodule : ref_input_selector

`default_nettype wire

// ---- tb/ref_input_config_tb.sv ----
// Self-checking bench for the reference input and divider configuration bank.
// Assumes the bank's assertions sit in its own files and the register port answers with no wait.
`timescale 1ns/1ps
`default_nettype none

module ref_input_config_tb;

  // ==========================================================================
  // Stimulus and observation signals.
  logic core_clk;
  logic rst;
  logic [clkcfg_pkg::ADDR_W-1:0] addr;
  logic [clkcfg_pkg::DATA_W-1:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [clkcfg_pkg::DATA_W-1:0] rd_data;
  logic ref_select_pin;
  logic primary_ok;
  logic secondary_ok;
  logic ref_edge;
  logic feedback_edge;
  clkcfg_pkg::input_ctl_s input_ctl;
  logic [clkcfg_pkg::REF_DIV_W-1:0] reference_divide_code;
  logic [clkcfg_pkg::FB_DIV_W-1:0] feedback_divide_code;
  logic use_secondary;
  logic secondary_buffer_on;
  logic ref_div_tick;
  logic feedback_div_tick;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int ref_ticks = 0;
  int fb_ticks = 0;
  logic [7:0] seen;

  // ==========================================================================
  // Device under test.
  ref_input_config i_ref_input_config (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .ref_select_pin(ref_select_pin), .primary_ok(primary_ok),
    .secondary_ok(secondary_ok), .ref_edge(ref_edge), .feedback_edge(feedback_edge),
    .input_ctl(input_ctl), .reference_divide_code(reference_divide_code),
    .feedback_divide_code(feedback_divide_code), .use_secondary(use_secondary),
    .secondary_buffer_on(secondary_buffer_on), .ref_div_tick(ref_div_tick),
    .feedback_div_tick(feedback_div_tick)
  );

  // ==========================================================================
  // Clock at 40 MHz.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Counts divided ticks and cuts a hung run short.
  always @(posedge core_clk) begin
    cycles++;
    if (ref_div_tick === 1'b1) ref_ticks++;
    if (feedback_div_tick === 1'b1) fb_ticks++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Tasks.
  // Compares one value against its expectation and counts the result.
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] expd);
    checks++;
    if (got !== expd) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, expd, got);
    end
  endtask : check

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data are taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // Lets a fixed number of edges pass and settles past the last one.
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  // Sends back-to-back pulses to one divider.
  task automatic pulses(input bit fb, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (fb) feedback_edge <= 1'b1;
      else ref_edge <= 1'b1;
    end
    @(posedge core_clk);
    ref_edge <= 1'b0;
    feedback_edge <= 1'b0;
  endtask : pulses

  // Code n must give no tick for n pulses and exactly one at pulse n+1.
  task automatic div_run(input bit fb, input logic [4:0] code);
    int base;
    wr(fb ? clkcfg_pkg::OFF_FB_DIV : clkcfg_pkg::OFF_REF_DIV, {3'h0, code});
    base = fb ? fb_ticks : ref_ticks;
    pulses(fb, int'(code));
    idle(2);
    check("ticks before ratio", 8'((fb ? fb_ticks : ref_ticks) - base), 8'h00);
    pulses(fb, 1);
    idle(2);
    check("ticks at ratio", 8'((fb ? fb_ticks : ref_ticks) - base), 8'h01);
  endtask : div_run

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Main sequence.
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ref_select_pin = 1'b0;
    primary_ok = 1'b1;
    secondary_ok = 1'b1;
    ref_edge = 1'b0;
    feedback_edge = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    idle(1);
    // Reset values through the port and at the outputs.
    rd(clkcfg_pkg::OFF_INPUT_CTL, seen);
    check("control reset", seen, 8'h03);
    check("control outputs", 8'(input_ctl), 8'h03);
    rd(clkcfg_pkg::OFF_REF_DIV, seen);
    check("reference divider reset", seen, 8'h00);
    rd(clkcfg_pkg::OFF_FB_DIV, seen);
    check("feedback divider reset", seen, 8'h00);
    // Every control bit writable, then gains cleared to minimum.
    wr(clkcfg_pkg::OFF_INPUT_CTL, 8'hFF);
    rd(clkcfg_pkg::OFF_INPUT_CTL, seen);
    check("control all ones", seen, 8'hFF);
    wr(clkcfg_pkg::OFF_INPUT_CTL, 8'h80);
    idle(1);
    check("control gains low", 8'(input_ctl), 8'h80);
    // Reserved divider bits drop writes and read zero.
    wr(clkcfg_pkg::OFF_REF_DIV, 8'hFF);
    rd(clkcfg_pkg::OFF_REF_DIV, seen);
    check("reference divider field", seen, 8'h07);
    check("reference code output", 8'(reference_divide_code), 8'h07);
    wr(clkcfg_pkg::OFF_FB_DIV, 8'hFF);
    rd(clkcfg_pkg::OFF_FB_DIV, seen);
    check("feedback divider field", seen, 8'h1F);
    check("feedback code output", 8'(feedback_divide_code), 8'h1F);
    rd(8'h40, seen);
    check("unmapped read", seen, 8'h00);
    // Divide ratios at bypass, smallest and largest codes.
    div_run(1'b0, 5'h00);
    div_run(1'b0, 5'h01);
    div_run(1'b0, 5'h07);
    div_run(1'b1, 5'h00);
    div_run(1'b1, 5'h01);
    div_run(1'b1, 5'h1F);
    // Mux skipped, secondary buffer released after switching back.
    wr(clkcfg_pkg::OFF_INPUT_CTL, 8'h83);
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_SECONDARY});
    idle(2);
    check("skip switch to secondary", 8'(use_secondary), 8'h01);
    check("buffer on at secondary", 8'(secondary_buffer_on), 8'h01);
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_PRIMARY});
    idle(2);
    check("back on primary", 8'(use_secondary), 8'h00);
    check("buffer off after return", 8'(secondary_buffer_on), 8'h00);
    // Keep bit holds the secondary buffer on after returning.
    wr(clkcfg_pkg::OFF_INPUT_CTL, 8'h87);
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_SECONDARY});
    idle(2);
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_PRIMARY});
    idle(2);
    check("buffer kept after return", 8'(secondary_buffer_on), 8'h01);
    rd(clkcfg_pkg::OFF_REF_STATUS, seen);
    check("status kept buffer", seen, 8'h02);
    // Automatic mode prefers primary and falls back to secondary.
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_AUTO});
    idle(2);
    check("auto with both good", 8'(use_secondary), 8'h00);
    @(posedge core_clk);
    primary_ok <= 1'b0;
    idle(2);
    check("auto primary lost", 8'(use_secondary), 8'h01);
    @(posedge core_clk);
    primary_ok <= 1'b1;
    idle(2);
    check("auto primary back", 8'(use_secondary), 8'h00);
    // Pin mode: pin high acts as automatic, pin low forces primary.
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_PIN});
    rd(clkcfg_pkg::OFF_REF_SELECT, seen);
    check("select read back", seen, 8'h01);
    @(posedge core_clk);
    ref_select_pin <= 1'b1;
    primary_ok <= 1'b0;
    idle(2);
    check("pin auto fallback", 8'(use_secondary), 8'h01);
    @(posedge core_clk);
    ref_select_pin <= 1'b0;
    primary_ok <= 1'b1;
    idle(2);
    check("pin forces primary", 8'(use_secondary), 8'h00);
    // Glitch-free mux in use: the switch waits for the handover.
    wr(clkcfg_pkg::OFF_INPUT_CTL, 8'h07);
    wr(clkcfg_pkg::OFF_REF_SELECT, {6'h00, clkcfg_pkg::SEL_SECONDARY});
    idle(2);
    check("handover pending", 8'(use_secondary), 8'h00);
    idle(1);
    check("handover still pending", 8'(use_secondary), 8'h00);
    idle(1);
    check("handover done", 8'(use_secondary), 8'h01);
    give_verdict();
  end

endmodule : ref_input_config_tb

`default_nettype wire
